// *** design/ccdrd_buf.sv ***
// two-entry valid/ready skid buffer
// assumes a single clock and asynchronous active-low reset
`default_nettype none
module ccdrd_buf #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_reg [2];
  logic rd_reg;
  logic wr_reg;
  logic [1:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rd_reg];
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      cnt_reg <= 2'h0;
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end
    else
    begin
      if (push) mem_reg[wr_reg] <= in_data;
      if (push) wr_reg <= ~wr_reg;
      if (pop) rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // ccdrd_buf
`default_nettype wire

// *** design/ccdrd_cfg.svh ***
// constants for the frame readout sequencer
// assumes a 50 MHz mclk; times are in ns and converted to cycle counts
`ifndef CCDRD_CFG_SVH
`define CCDRD_CFG_SVH
`define CCDRD_CLK_NS 20
`define CCDRD_LINES 1032
`define CCDRD_HREG_LEN 1564
`define CCDRD_LEAD_DUMMY 10
`define CCDRD_TRAIL_DUMMY 2
`define CCDRD_LEAD_DARK 4
`define CCDRD_TRAIL_DARK 12
`define CCDRD_DARK_LINES 4
`define CCDRD_TV_NS 5000
`define CCDRD_THS_NS 1000
`define CCDRD_TPIX_NS 260
`define CCDRD_TRST_NS 20
`define CCDRD_TV_CYC ((`CCDRD_TV_NS + `CCDRD_CLK_NS - 1) / `CCDRD_CLK_NS)
`define CCDRD_THS_CYC ((`CCDRD_THS_NS + `CCDRD_CLK_NS - 1) / `CCDRD_CLK_NS)
`define CCDRD_HALF_CYC (((`CCDRD_TPIX_NS + `CCDRD_CLK_NS - 1) / `CCDRD_CLK_NS + 1) / 2)
`define CCDRD_RST_CYC ((`CCDRD_TRST_NS + `CCDRD_CLK_NS - 1) / `CCDRD_CLK_NS)
`endif

// *** design/ccdrd_pkg.sv ***
// types for the frame readout sequencer
// assumes the cfg header is compiled alongside
`default_nettype none
package ccdrd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_INTEG, ST_V1, ST_V2, ST_V3, ST_HSET, ST_HA, ST_HB
  } ccdrd_state_t;
  typedef enum logic [1:0] {
    PK_DUMMY, PK_DARK, PK_IMAGE
  } ccdrd_kind_t;
endpackage
`default_nettype wire

// *** design/ccdrd_seq.sv ***
// full-frame sensor readout sequencer (controller side)
// assumes sensor pins driven through level shifters; video sampled by an adc
`include "ccdrd_cfg.svh"
`default_nettype none
module ccdrd_seq #(
  parameter int LINES = `CCDRD_LINES,
  parameter int HLEN = `CCDRD_HREG_LEN,
  parameter int INT_CYC = 5000
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  output logic busy,
  output logic vertical_phase_a,
  output logic vertical_phase_b,
  output logic horizontal_phase_a,
  output logic horizontal_phase_b,
  output logic reset_gate,
  output logic shutter_open,
  output logic sample_strobe,
  input wire logic [15:0] video_data,
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [15:0] pix_data,
  output logic [1:0] pix_kind,
  output logic pix_first,
  output logic pix_last,
  output logic frame_done
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ccdrd_pkg::ccdrd_state_t st_reg, st_next;
  logic [31:0] tmr_reg;
  logic [10:0] line_reg;
  logic [10:0] pix_reg;
  logic [1:0] rst_reg;
  logic smp_reg;
  logic done_reg;
  logic [19:0] cap_reg;
  logic cap_vld_reg;
  logic [1:0] pix_kind_q;
  logic first_q;
  logic last_q;
  wire buf_in_ready;
  wire tmr_zero = (tmr_reg == 32'h0);
  wire last_pix = (pix_reg == 11'(HLEN - 1));
  wire last_line = (line_reg == 11'(LINES - 1));
  // stall only at a pixel boundary, so held phases never stretch mid-pixel
  wire can_go = tmr_zero && (!cap_vld_reg || buf_in_ready);
  // ----------------------------------------------------------------
  // pixel classification
  // ----------------------------------------------------------------
  wire in_lead = pix_reg < 11'(`CCDRD_LEAD_DUMMY);
  wire in_trail = pix_reg >= 11'(HLEN - `CCDRD_TRAIL_DUMMY);
  wire col_dark = (pix_reg < 11'(`CCDRD_LEAD_DUMMY + `CCDRD_LEAD_DARK)) ||
    (pix_reg >= 11'(HLEN - `CCDRD_TRAIL_DUMMY - `CCDRD_TRAIL_DARK));
  wire row_dark = (line_reg < 11'(`CCDRD_DARK_LINES)) ||
    (line_reg >= 11'(LINES - `CCDRD_DARK_LINES));
  wire [1:0] kind_w = (in_lead || in_trail) ? 2'(ccdrd_pkg::PK_DUMMY) :
    (col_dark || row_dark) ? 2'(ccdrd_pkg::PK_DARK) : 2'(ccdrd_pkg::PK_IMAGE);
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      ccdrd_pkg::ST_IDLE: if (start) st_next = ccdrd_pkg::ST_INTEG;
      ccdrd_pkg::ST_INTEG: if (tmr_zero) st_next = ccdrd_pkg::ST_V1;
      ccdrd_pkg::ST_V1: if (tmr_zero) st_next = ccdrd_pkg::ST_V2;
      ccdrd_pkg::ST_V2: if (tmr_zero) st_next = ccdrd_pkg::ST_V3;
      ccdrd_pkg::ST_V3: if (tmr_zero) st_next = ccdrd_pkg::ST_HSET;
      ccdrd_pkg::ST_HSET: if (can_go) st_next = ccdrd_pkg::ST_HA;
      ccdrd_pkg::ST_HA: if (tmr_zero) st_next = ccdrd_pkg::ST_HB;
      ccdrd_pkg::ST_HB:
        if (can_go)
          st_next = !last_pix ? ccdrd_pkg::ST_HA :
            last_line ? ccdrd_pkg::ST_IDLE : ccdrd_pkg::ST_V1;
    endcase
  end
  wire enter = (st_next != st_reg);
  wire hb_fall = (st_reg == ccdrd_pkg::ST_HB) && can_go;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= ccdrd_pkg::ST_IDLE;
    else
      st_reg <= st_next;
  end
  // ----------------------------------------------------------------
  // interval timer
  // ----------------------------------------------------------------
  logic [31:0] tmr_next;
  always_comb
  begin
    tmr_next = tmr_zero ? 32'h0 : tmr_reg - 32'h1;
    if (enter)
    begin
      unique case (st_next)
        ccdrd_pkg::ST_INTEG: tmr_next = 32'(INT_CYC - 1);
        ccdrd_pkg::ST_V1, ccdrd_pkg::ST_V2, ccdrd_pkg::ST_V3:
          tmr_next = 32'(`CCDRD_TV_CYC - 1);
        ccdrd_pkg::ST_HSET: tmr_next = 32'(`CCDRD_THS_CYC - 1);
        ccdrd_pkg::ST_HA, ccdrd_pkg::ST_HB: tmr_next = 32'(`CCDRD_HALF_CYC - 1);
        ccdrd_pkg::ST_IDLE: tmr_next = 32'h0;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      tmr_reg <= 32'h0;
    else
      tmr_reg <= tmr_next;
  end
  // ----------------------------------------------------------------
  // line and pixel counters
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      line_reg <= 11'h0;
      pix_reg <= 11'h0;
    end
    else
    begin
      if (st_reg == ccdrd_pkg::ST_IDLE) line_reg <= 11'h0;
      else if (hb_fall && last_pix) line_reg <= line_reg + 11'h1;
      if (st_reg == ccdrd_pkg::ST_V1) pix_reg <= 11'h0;
      else if (hb_fall) pix_reg <= pix_reg + 11'h1;
    end
  end
  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // integration and idle leave both vertical phases low
  assign vertical_phase_a = (st_reg == ccdrd_pkg::ST_V1);
  // phase b falls leaving v2, with horizontal a held high there
  assign vertical_phase_b = (st_reg == ccdrd_pkg::ST_V2);
  assign horizontal_phase_a = (st_reg == ccdrd_pkg::ST_V1) || (st_reg == ccdrd_pkg::ST_V2) ||
    (st_reg == ccdrd_pkg::ST_V3) || (st_reg == ccdrd_pkg::ST_HSET) ||
    (st_reg == ccdrd_pkg::ST_HA);
  assign horizontal_phase_b = ~horizontal_phase_a &&
    (st_reg == ccdrd_pkg::ST_HB);
  assign shutter_open = (st_reg == ccdrd_pkg::ST_INTEG);
  assign busy = (st_reg != ccdrd_pkg::ST_IDLE);
  assign reset_gate = (rst_reg != 2'h0);
  assign sample_strobe = smp_reg;
  assign frame_done = done_reg;
  // ----------------------------------------------------------------
  // sampling, reset gate and capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      smp_reg <= 1'b0;
      rst_reg <= 2'h0;
      cap_vld_reg <= 1'b0;
      cap_reg <= 20'h0;
      done_reg <= 1'b0;
    end
    else
    begin
      smp_reg <= hb_fall;
      // reset follows the sample, one cycle after the strobe
      if (smp_reg) rst_reg <= 2'(`CCDRD_RST_CYC);
      else if (rst_reg != 2'h0) rst_reg <= rst_reg - 2'h1;
      if (smp_reg)
      begin
        cap_vld_reg <= 1'b1;
        cap_reg <= {video_data, pix_kind_q, first_q, last_q};
      end
      else if (buf_in_ready) cap_vld_reg <= 1'b0;
      done_reg <= hb_fall && last_pix && last_line;
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pix_kind_q <= 2'h0;
      first_q <= 1'b0;
      last_q <= 1'b0;
    end
    else if (hb_fall)
    begin
      pix_kind_q <= kind_w;
      first_q <= (pix_reg == 11'h0);
      last_q <= last_pix;
    end
  end
  // ----------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------
  wire [19:0] buf_out;
  ccdrd_buf #(.W(20)) u_buf (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(cap_vld_reg),
    .in_ready(buf_in_ready),
    .in_data(cap_reg),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(buf_out)
  );
  assign pix_data = buf_out[19:4];
  assign pix_kind = buf_out[3:2];
  assign pix_first = buf_out[1];
  assign pix_last = buf_out[0];
endmodule // ccdrd_seq
`default_nettype wire

// *** sim/ccdrd_sensor_model.sv ***
// sensor model: line load and pixel shift onto the sense node
// assumes phase pins from the sequencer, video back to it
`default_nettype none
module ccdrd_sensor_model #(
  parameter int LINES = 10
) (
  input wire logic nrst,
  input wire logic vertical_phase_b,
  input wire logic horizontal_phase_a,
  input wire logic horizontal_phase_b,
  input wire logic reset_gate,
  output logic [15:0] video_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int row = -1;
  int elem = 0;
  initial video_data = 16'h0000;
  always @(negedge nrst) row = -1;
  // line lands only when phase a is high
  always @(negedge vertical_phase_b)
    if (nrst && horizontal_phase_a)
    begin
      row = (row + 1) % LINES;
      elem = 0;
    end
  // packet tags row and element; dummies and dark keep their slots
  always @(negedge horizontal_phase_b)
    if (nrst)
    begin
      video_data = {row[7:0], elem[7:0]};
      elem++;
    end
  // cleared node never shows the old level
  always @(posedge reset_gate) video_data = ~video_data;
endmodule // ccdrd_sensor_model
`default_nettype wire

// *** sim/ccdrd_seq_asserts.sv ***
// checker on the sequencer pins
// assumes bound onto ccdrd_seq, one clock
`default_nettype none
module ccdrd_seq_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  input wire logic busy,
  input wire logic vertical_phase_a,
  input wire logic vertical_phase_b,
  input wire logic horizontal_phase_a,
  input wire logic horizontal_phase_b,
  input wire logic reset_gate,
  input wire logic shutter_open,
  input wire logic sample_strobe,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [15:0] pix_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [8:0] va_cnt_reg;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      va_cnt_reg <= 9'h000;
    else
      va_cnt_reg <= vertical_phase_a ? va_cnt_reg + 9'h001 : 9'h000;
  a_integ_parked: assert property (
    shutter_open |-> !vertical_phase_a && !vertical_phase_b)
    else $error("vertical phase moved in integration");
  a_dark_readout: assert property (
    vertical_phase_a || horizontal_phase_b |-> !shutter_open)
    else $error("shutter open in readout");
  a_start_opens: assert property (start && !busy |-> ##[1:2] shutter_open)
    else $error("start did not open shutter");
  a_xfer_ha_high: assert property ($fell(vertical_phase_b) |-> horizontal_phase_a)
    else $error("line moved with phase a low");
  a_va_width: assert property (
    $fell(vertical_phase_a) |-> va_cnt_reg == 9'h0FA && vertical_phase_b)
    else $error("vertical phase a width wrong");
  a_h_complement: assert property (!(horizontal_phase_a && horizontal_phase_b))
    else $error("horizontal phases overlap");
  a_hb_sample: assert property ($fell(horizontal_phase_b) |-> ##[0:1] sample_strobe)
    else $error("no sample after phase b fall");
  a_rg_after: assert property (sample_strobe |=> reset_gate ##1 !reset_gate)
    else $error("reset gate not after sample");
  a_pix_hold: assert property (
    pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
    else $error("pixel dropped under stall");
  c_stall: cover property (pix_valid && !pix_ready ##1 pix_valid && pix_ready);
  c_xfer: cover property ($fell(vertical_phase_b));
  c_busy_start: cover property (busy && start);
endmodule // ccdrd_seq_chk
bind ccdrd_seq ccdrd_seq_chk u_chk (.mclk, .nrst, .start, .busy, .vertical_phase_a,
  .vertical_phase_b, .horizontal_phase_a, .horizontal_phase_b, .reset_gate, .shutter_open,
  .sample_strobe, .pix_valid, .pix_ready, .pix_data);
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the readout sequencer
// assumes design files compiled first; sensor model on the pins
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LINES = 10;
  localparam int HLEN = 40;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic pix_ready = 1'b0;
  logic busy, vertical_phase_a, vertical_phase_b, horizontal_phase_a, horizontal_phase_b;
  logic reset_gate, shutter_open, sample_strobe, pix_valid, pix_first, pix_last, frame_done;
  logic [15:0] video_data, pix_data;
  logic [1:0] pix_kind;
  logic [15:0] lfsr = 16'h4D12;
  logic [19:0] exp_q[$];
  int failures = 0;
  int samples_checked = 0;
  int dones = 0;
  int stall = 0;
  logic rnd = 1'b1;
  ccdrd_seq #(.LINES(LINES), .HLEN(HLEN), .INT_CYC(4)) u_dut (.mclk, .nrst, .start, .busy,
    .vertical_phase_a, .vertical_phase_b, .horizontal_phase_a, .horizontal_phase_b,
    .reset_gate, .shutter_open, .sample_strobe, .video_data, .pix_valid, .pix_ready,
    .pix_data, .pix_kind, .pix_first, .pix_last, .frame_done);
  ccdrd_sensor_model #(.LINES(LINES)) u_sensor (.nrst, .vertical_phase_b,
    .horizontal_phase_a, .horizontal_phase_b, .reset_gate, .video_data);
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  // long stalls so the buffer fills and the sequencer must hold
  always @(posedge mclk)
  begin
    #1;
    lfsr = lfsr_next(lfsr);
    if (stall > 0) stall--;
    else if (rnd && lfsr[5:0] == 6'h00) stall = 40;
    pix_ready = (stall == 0);
  end
  always @(posedge mclk)
    if (nrst && frame_done) dones++;
  always @(posedge mclk)
    if (nrst && pix_valid && pix_ready)
    begin
      `CHK(pix_data, exp_q[0][15:0])
      `CHK({pix_kind, pix_first, pix_last}, exp_q[0][19:16])
      void'(exp_q.pop_front());
    end
  task automatic end_sim();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic run_frame(input int lim, input bit abort);
    int k;
    int i;
    int d0;
    exp_q.delete();
    for (int r = 0; r < LINES; r++)
      for (int e = 0; e < HLEN; e++)
      begin
        k = 2;
        if (e < 14 || e >= HLEN - 14 || r < 4 || r >= LINES - 4) k = 1;
        if (e < 10 || e >= HLEN - 2) k = 0;
        exp_q.push_back({k[1:0], e == 0, e == HLEN - 1, r[7:0], e[7:0]});
      end
    d0 = dones;
    start = 1'b1;
    @(posedge mclk);
    #1 start = 1'b0;
    for (i = 0; i < lim && (exp_q.size() > 0 || dones == d0); i++)
    begin
      @(posedge mclk);
      #1;
      start = (i == 3000);
      if (i == 3010) `CHK(shutter_open, 1'b0)
    end
    if (abort) return;
    if (i == lim)
    begin
      failures++;
      end_sim();
    end
    `CHK(dones - d0, 1)
    repeat (3) @(posedge mclk);
    #1 `CHK(busy, 1'b0)
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    #1 nrst = 1'b1;
    run_frame(60000, 1'b0);
    run_frame(2000, 1'b1);
    nrst = 1'b0;
    #1 `CHK({vertical_phase_a, vertical_phase_b, shutter_open, busy, pix_valid}, 5'h00)
    repeat (2) @(posedge mclk);
    #1 nrst = 1'b1;
    rnd = 1'b0;
    run_frame(30000, 1'b0);
    end_sim();
  end
endmodule // tb
`default_nettype wire
